/* File: design/dpnv_cfg.svh */
// constants of the serial digital potentiometer with nonvolatile store
`ifndef DPNV_CFG_SVH
`define DPNV_CFG_SVH

`define DPNV_WIPER_W        10
`define DPNV_WIPER_MAX      10'h3FF
`define DPNV_WIPER_MID      10'h200
`define DPNV_WIPER_ONE      10'h001
`define DPNV_USER_WORDS     14
`define DPNV_WORD_W         16
`define DPNV_ADDR_W         4
`define DPNV_NV_WIPER_IDX   4'h0
`define DPNV_USER_BASE      4'h1

// frame: command nibble, address nibble, data word, msb first
`define DPNV_FRAME_BITS     5'h18
`define DPNV_BITCNT_MAX     5'h1F

// command codes
`define DPNV_CMD_NOP        4'h0
`define DPNV_CMD_NV_TO_WIP  4'h1
`define DPNV_CMD_WIP_TO_NV  4'h2
`define DPNV_CMD_USER_WR    4'h3
`define DPNV_CMD_USER_RD    4'h4
`define DPNV_CMD_DEC_LOG    4'h5
`define DPNV_CMD_INC_LOG    4'h6
`define DPNV_CMD_DEC_LIN    4'h7
`define DPNV_CMD_INC_LIN    4'h8
`define DPNV_CMD_WIP_RD     4'h9
`define DPNV_CMD_WIP_WR     4'hB

// timing, in microseconds, and clock rate
`define DPNV_CLK_MHZ        100
`define DPNV_NV_WRITE_US    25000
`define DPNV_NV_READ_US     1
`define DPNV_RDY_PULSE_US   1

`endif

/* File: design/dpnv_pin_sync.sv */
// two-stage synchroniser for the link pins
`timescale 1ns/1ns
module dpnv_pin_sync
    import dpnv_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire dpnv_link_t pins_in,
    output dpnv_link_t      pins_out
);
    dpnv_link_t meta_r;
    dpnv_link_t sync_r;

    // idle link levels after reset: clock low, select high
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            meta_r <= '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0};
            sync_r <= '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0};
        end else begin
            meta_r <= pins_in;
            sync_r <= meta_r;
        end
    end

    assign pins_out = sync_r;
endmodule

/* File: design/dpnv_pkg.sv */
// types of the serial digital potentiometer with nonvolatile store
`include "dpnv_cfg.svh"
package dpnv_pkg;

    typedef struct packed {
        logic [3:0]                 cmd;
        logic [`DPNV_ADDR_W-1:0]    addr;
        logic [`DPNV_WORD_W-1:0]    data;
    } dpnv_frame_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic sdi;
    } dpnv_link_t;

    typedef enum logic [2:0] {
        DPNV_RESTORE,
        DPNV_IDLE,
        DPNV_NV_WRITE,
        DPNV_NV_READ,
        DPNV_RDY_PULSE
    } dpnv_state_t;

endpackage

/* File: design/dpnv_top.sv */
// command interpreter, wiper register and nonvolatile store
`timescale 1ns/1ns
`include "dpnv_cfg.svh"
module dpnv_top
    import dpnv_pkg::*;
#(
    parameter int unsigned USER_WORDS   = `DPNV_USER_WORDS,
    parameter int unsigned WRITE_CYCLES = `DPNV_NV_WRITE_US * `DPNV_CLK_MHZ,
    parameter int unsigned READ_CYCLES  = `DPNV_NV_READ_US * `DPNV_CLK_MHZ,
    parameter int unsigned PULSE_CYCLES = `DPNV_RDY_PULSE_US * `DPNV_CLK_MHZ
)
(
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    input  wire logic                      sck_in,
    input  wire logic                      cs_n_in,
    input  wire logic                      sdi_in,
    output logic                           sdo_out,
    output logic                           sdo_oe_out,
    output logic                           ready_n_out,
    output logic                           ready_n_oe_out,
    output logic                           busy_out,
    output logic [`DPNV_WIPER_W-1:0]       wiper_out
);
    localparam int unsigned NV_DEPTH = USER_WORDS + 1;

    // pin synchronisation
    dpnv_link_t pins_raw;
    dpnv_link_t pins_s;

    assign pins_raw = '{sck: sck_in, cs_n: cs_n_in, sdi: sdi_in};

    dpnv_pin_sync u_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .pins_in  (pins_raw),
        .pins_out (pins_s)
    );

    // edge detection on the synchronised levels only
    logic sck_prev_r;
    logic cs_prev_r;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sck_prev_r <= 1'b0;
            cs_prev_r  <= 1'b1;
        end else begin
            sck_prev_r <= pins_s.sck;
            cs_prev_r  <= pins_s.cs_n;
        end
    end

    assign sck_rise = pins_s.sck & ~sck_prev_r & ~pins_s.cs_n;
    assign sck_fall = ~pins_s.sck & sck_prev_r & ~pins_s.cs_n;
    assign cs_fall  = ~pins_s.cs_n & cs_prev_r;
    assign cs_rise  = pins_s.cs_n & ~cs_prev_r;

    // receive shifter: data taken on rising clock, msb first
    dpnv_frame_t             rx_r;
    logic [4:0]              bitcnt_r;
    logic                    frame_ok;
    dpnv_frame_t             readback_r;
    logic [$bits(dpnv_frame_t)-1:0] tx_r;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_r     <= '0;
            bitcnt_r <= 5'h00;
        end else if (cs_fall) begin
            bitcnt_r <= 5'h00;
        end else if (sck_rise) begin
            rx_r <= {rx_r[$bits(dpnv_frame_t)-2:0], pins_s.sdi};
            // saturate so an overlong frame is never mistaken for a good one
            if (bitcnt_r != `DPNV_BITCNT_MAX)
                bitcnt_r <= bitcnt_r + 5'h01;
        end
    end

    // only frames of exactly the expected length are acted upon
    assign frame_ok = cs_rise && (bitcnt_r == `DPNV_FRAME_BITS);

    // transmit shifter: readback loaded at select, shifted on falling clock
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_r <= '0;
        end else if (cs_fall) begin
            tx_r <= readback_r;
        end else if (sck_fall) begin
            tx_r <= {tx_r[$bits(dpnv_frame_t)-2:0], 1'b0};
        end
    end

    // data line driven only while selected
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sdo_out    <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else begin
            sdo_out    <= tx_r[$bits(dpnv_frame_t)-1];
            sdo_oe_out <= ~pins_s.cs_n;
        end
    end

    // wiper step arithmetic, saturating at both ends
    function automatic logic [`DPNV_WIPER_W-1:0] wiper_step(
        input logic [`DPNV_WIPER_W-1:0] w,
        input logic                     up,
        input logic                     log_mode
    );
        logic [`DPNV_WIPER_W-1:0] res;
        res = w;
        if (log_mode && up) begin
            // doubling is one 6 dB step; zero has to leave via one
            if (w == '0)
                res = `DPNV_WIPER_ONE;
            else if (w[`DPNV_WIPER_W-1])
                res = `DPNV_WIPER_MAX;
            else
                res = {w[`DPNV_WIPER_W-2:0], 1'b0};
        end else if (log_mode) begin
            res = {1'b0, w[`DPNV_WIPER_W-1:1]};
        end else if (up) begin
            if (w != `DPNV_WIPER_MAX)
                res = w + `DPNV_WIPER_ONE;
        end else begin
            if (w != '0)
                res = w - `DPNV_WIPER_ONE;
        end
        return res;
    endfunction

    // user address to store index; out-of-range addresses fold to none
    function automatic logic user_addr_ok(input logic [`DPNV_ADDR_W-1:0] a);
        return (32'(a) < USER_WORDS);
    endfunction

    // nonvolatile store: index 0 keeps the wiper, the rest are user words
    logic [`DPNV_WORD_W-1:0] nv_mem [NV_DEPTH];

    // factory content: wiper at mid-scale, user words clear
    initial begin
        for (int i = 0; i < NV_DEPTH; i++)
            nv_mem[i] = '0;
        nv_mem[0] = {{(`DPNV_WORD_W-`DPNV_WIPER_W){1'b0}}, `DPNV_WIPER_MID};
    end

    // control state
    dpnv_state_t              state_r;
    logic [31:0]              cnt_r;
    logic [`DPNV_ADDR_W-1:0]  op_idx_r;
    logic [`DPNV_WORD_W-1:0]  op_data_r;
    logic                     op_to_wiper_r;
    logic [`DPNV_WIPER_W-1:0] wiper_r;
    logic                     accept;
    logic                     cnt_done;

    // commands are taken only while idle; anything else is dropped
    assign accept   = frame_ok && (state_r == DPNV_IDLE);
    assign cnt_done = (cnt_r == 32'h0);
    assign busy_out = (state_r != DPNV_IDLE);

    // sequencer for restore, store timing and ready pulse
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_r <= DPNV_RESTORE;
            cnt_r   <= 32'h0;
        end else begin
            unique case (state_r)
                DPNV_RESTORE: begin
                    state_r <= DPNV_RDY_PULSE;
                    cnt_r   <= PULSE_CYCLES - 1;
                end
                DPNV_IDLE: begin
                    if (accept) begin
                        unique case (rx_r.cmd)
                            `DPNV_CMD_WIP_TO_NV: begin
                                state_r <= DPNV_NV_WRITE;
                                cnt_r   <= WRITE_CYCLES - 1;
                            end
                            `DPNV_CMD_USER_WR: begin
                                if (user_addr_ok(rx_r.addr)) begin
                                    state_r <= DPNV_NV_WRITE;
                                    cnt_r   <= WRITE_CYCLES - 1;
                                end
                            end
                            `DPNV_CMD_NV_TO_WIP,
                            `DPNV_CMD_USER_RD: begin
                                state_r <= DPNV_NV_READ;
                                cnt_r   <= READ_CYCLES - 1;
                            end
                            default: begin
                                state_r <= DPNV_IDLE;
                            end
                        endcase
                    end
                end
                DPNV_NV_WRITE: begin
                    // the whole write interval is spent busy
                    if (cnt_done) begin
                        state_r <= DPNV_RDY_PULSE;
                        cnt_r   <= PULSE_CYCLES - 1;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                DPNV_NV_READ: begin
                    if (cnt_done) begin
                        state_r <= DPNV_RDY_PULSE;
                        cnt_r   <= PULSE_CYCLES - 1;
                    end else begin
                        cnt_r <= cnt_r - 32'h1;
                    end
                end
                DPNV_RDY_PULSE: begin
                    if (cnt_done)
                        state_r <= DPNV_IDLE;
                    else
                        cnt_r <= cnt_r - 32'h1;
                end
            endcase
        end
    end

    // operation latch: what the pending store or read acts on
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            op_idx_r      <= `DPNV_NV_WIPER_IDX;
            op_data_r     <= '0;
            op_to_wiper_r <= 1'b1;
        end else if (state_r == DPNV_RESTORE) begin
            op_idx_r      <= `DPNV_NV_WIPER_IDX;
            op_to_wiper_r <= 1'b1;
        end else if (accept) begin
            unique case (rx_r.cmd)
                `DPNV_CMD_WIP_TO_NV: begin
                    op_idx_r  <= `DPNV_NV_WIPER_IDX;
                    op_data_r <= {{(`DPNV_WORD_W-`DPNV_WIPER_W){1'b0}}, wiper_r};
                end
                `DPNV_CMD_NV_TO_WIP: begin
                    op_idx_r      <= `DPNV_NV_WIPER_IDX;
                    op_to_wiper_r <= 1'b1;
                end
                `DPNV_CMD_USER_WR: begin
                    op_idx_r  <= rx_r.addr + `DPNV_USER_BASE;
                    op_data_r <= rx_r.data;
                end
                `DPNV_CMD_USER_RD: begin
                    op_idx_r      <= rx_r.addr + `DPNV_USER_BASE;
                    op_to_wiper_r <= 1'b0;
                end
                default: begin
                    op_idx_r <= op_idx_r;
                end
            endcase
        end
    end

    // store commits at the end of the write interval, as real cells would
    always_ff @(posedge clk_in) begin
        if (state_r == DPNV_NV_WRITE && cnt_done)
            nv_mem[op_idx_r] <= op_data_r;
    end

    // wiper register: restore, direct load and step commands
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wiper_r <= `DPNV_WIPER_MID;
        end else if (state_r == DPNV_RESTORE) begin
            wiper_r <= nv_mem[0][`DPNV_WIPER_W-1:0];
        end else if (state_r == DPNV_NV_READ && cnt_done && op_to_wiper_r) begin
            wiper_r <= nv_mem[0][`DPNV_WIPER_W-1:0];
        end else if (accept) begin
            unique case (rx_r.cmd)
                `DPNV_CMD_WIP_WR:  wiper_r <= rx_r.data[`DPNV_WIPER_W-1:0];
                `DPNV_CMD_INC_LOG: wiper_r <= wiper_step(wiper_r, 1'b1, 1'b1);
                `DPNV_CMD_DEC_LOG: wiper_r <= wiper_step(wiper_r, 1'b0, 1'b1);
                `DPNV_CMD_INC_LIN: wiper_r <= wiper_step(wiper_r, 1'b1, 1'b0);
                `DPNV_CMD_DEC_LIN: wiper_r <= wiper_step(wiper_r, 1'b0, 1'b0);
                default:           wiper_r <= wiper_r;
            endcase
        end
    end

    assign wiper_out = wiper_r;

    // readback word shifted out during the next frame
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            readback_r <= '0;
        end else if (state_r == DPNV_NV_READ && cnt_done && !op_to_wiper_r) begin
            readback_r.cmd  <= `DPNV_CMD_USER_RD;
            readback_r.addr <= op_idx_r - `DPNV_USER_BASE;
            // an address past the user area reads back as zero, never off the array
            readback_r.data <= user_addr_ok(op_idx_r - `DPNV_USER_BASE)
                               ? nv_mem[op_idx_r] : '0;
        end else if (accept && rx_r.cmd == `DPNV_CMD_WIP_RD) begin
            readback_r.cmd  <= `DPNV_CMD_WIP_RD;
            readback_r.addr <= '0;
            readback_r.data <= {{(`DPNV_WORD_W-`DPNV_WIPER_W){1'b0}}, wiper_r};
        end else if (accept && rx_r.cmd == `DPNV_CMD_USER_RD
                     && !user_addr_ok(rx_r.addr)) begin
            readback_r <= '0;
        end
    end

    // ready is open drain: pulled low for the pulse, released otherwise
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ready_n_out    <= 1'b0;
            ready_n_oe_out <= 1'b0;
        end else begin
            ready_n_out    <= 1'b0;
            ready_n_oe_out <= (state_r == DPNV_RDY_PULSE);
        end
    end
endmodule

/* File: test/dpnv_host_model.sv */
// host controller model that drives the serial link
`timescale 1ns/1ns
module dpnv_host_model
    import dpnv_pkg::*;
(
    output dpnv_link_t link_out,
    input  wire logic  sdo_in,
    input  wire logic  sdo_oe_in,
    input  wire logic  rdy_pin_in
);
    int rdy_cnt = 0;

    // idle link: clock low, device deselected
    initial link_out = '{sck: 1'b0, cs_n: 1'b1, sdi: 1'b0};

    // every low-going ready pulse ends a power-up restore, a store, a recall or a user read
    always @(negedge rdy_pin_in) rdy_cnt++;

    // mode 0 frame, msb first; the clock runs only inside the frame
    task automatic xfer(input dpnv_frame_t f, input int nbits, output dpnv_frame_t rx);
        rx = '0;
        link_out.cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            link_out.sdi = f[23 - i];
            #62 link_out.sck = 1'b1;
            rx[23 - i] = sdo_oe_in ? sdo_in : 1'bx;
            #63 link_out.sck = 1'b0;
        end
        #62 link_out.cs_n = 1'b1;
        link_out.sdi = ~link_out.sdi;  // a released line must not keep its last level
    endtask
endmodule

/* File: test/dpnv_properties.sv */
// port-timing checker of the potentiometer command block
`timescale 1ns/1ns
`include "dpnv_cfg.svh"
module dpnv_properties #(
    parameter int unsigned PULSE_CYCLES = 100
)
(
    input wire logic                     clk_in,
    input wire logic                     reset_in,
    input wire logic                     sck_in,
    input wire logic                     cs_n_in,
    input wire logic                     sdi_in,
    input wire logic                     sdo_out,
    input wire logic                     sdo_oe_out,
    input wire logic                     ready_n_out,
    input wire logic                     ready_n_oe_out,
    input wire logic                     busy_out,
    input wire logic [`DPNV_WIPER_W-1:0] wiper_out
);
    logic [15:0] pulse_cnt_r;

    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // clocks spent so far in the current ready pulse
    always_ff @(posedge clk_in) begin
        if (reset_in || !ready_n_oe_out) begin
            pulse_cnt_r <= 16'h0000;
        end else begin
            pulse_cnt_r <= pulse_cnt_r + 16'h0001;
        end
    end

    // the pin may only be pulled low, never driven high
    property p_ready_low; ready_n_oe_out |-> !ready_n_out; endproperty
    // the pin register lags the sequencer by one clock
    property p_pulse_busy; ready_n_oe_out |-> $past(busy_out); endproperty
    property p_pulse_len; $fell(ready_n_oe_out) |-> pulse_cnt_r == 16'(PULSE_CYCLES); endproperty
    property p_busy_end; $fell(busy_out) |-> $past(ready_n_oe_out) || $past(ready_n_oe_out, 2);
    endproperty
    property p_pulse_cause; $rose(ready_n_oe_out) |-> $past(busy_out); endproperty
    property p_oe_sel; !cs_n_in [*6] |-> sdo_oe_out; endproperty
    property p_oe_unsel; cs_n_in [*6] |-> !sdo_oe_out; endproperty
    // a wiper change follows a finished frame, never a frame in flight
    property p_wiper_cs; $changed(wiper_out) |-> $past(cs_n_in, 2); endproperty
    property p_sdo_edge; $changed(sdo_out) |-> !$past(sck_in, 2); endproperty

    a_ready_low: assert property (p_ready_low) else $error("ready pin driven high");
    a_pulse_busy: assert property (p_pulse_busy) else $error("pulse outside busy");
    a_pulse_len: assert property (p_pulse_len) else $error("ready pulse length");
    a_busy_end: assert property (p_busy_end) else $error("busy ended without pulse");
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without op");
    a_oe_sel: assert property (p_oe_sel) else $error("sdo not driven when selected");
    a_oe_unsel: assert property (p_oe_unsel) else $error("sdo driven unselected");
    a_wiper_cs: assert property (p_wiper_cs) else $error("wiper moved mid-frame");
    a_sdo_edge: assert property (p_sdo_edge) else $error("sdo moved with clock high");

    c_pulse: cover property ($fell(ready_n_oe_out));
    c_wiper: cover property ($changed(wiper_out));
    c_select: cover property ($rose(sdo_oe_out));
endmodule

bind dpnv_top dpnv_properties #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (
    .clk_in(clk_in), .reset_in(reset_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
    .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .ready_n_out(ready_n_out),
    .ready_n_oe_out(ready_n_oe_out), .busy_out(busy_out), .wiper_out(wiper_out));

/* File: test/dpnv_top_tb.sv */
// self-checking bench of the potentiometer command block
`timescale 1ns/1ns
`include "dpnv_cfg.svh"
`define CHK(name, exp, got) \
    begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", name, exp, got); end end
module dpnv_top_tb
    import dpnv_pkg::*;
;
    localparam int unsigned WR_CYC = 600;  // longer than a frame, so one can land inside
    logic                     clk_in;
    logic                     reset_in;
    logic                     sdo, sdo_oe, rdy_n, rdy_oe, busy;
    logic [`DPNV_WIPER_W-1:0] wiper, w;
    dpnv_link_t               link;
    dpnv_frame_t              rx;
    wire logic                rdy_pin = rdy_oe ? rdy_n : 1'b1;  // board pull-up
    int                       error_cnt = 0, total_checks = 0, i, n, c;
    time                      t0;
    logic [31:0]              seed = 32'h00000049;
    logic [15:0]              ud [15];

    dpnv_top #(.WRITE_CYCLES(WR_CYC), .READ_CYCLES(4), .PULSE_CYCLES(4)) dut_u (
        .clk_in(clk_in), .reset_in(reset_in), .sck_in(link.sck), .cs_n_in(link.cs_n),
        .sdi_in(link.sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .ready_n_out(rdy_n),
        .ready_n_oe_out(rdy_oe), .busy_out(busy), .wiper_out(wiper));
    dpnv_host_model host_u (.link_out(link), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
        .rdy_pin_in(rdy_pin));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // expected wiper after one step; both kinds saturate at the ends
    function automatic logic [9:0] step_exp(logic [9:0] v, logic [3:0] cmd);
        case (cmd)
            4'h5: return v >> 1;
            4'h6: return (v == 10'h000) ? 10'h001 : (v[9] ? 10'h3FF : v << 1);
            4'h7: return (v == 10'h000) ? 10'h000 : v - 10'h001;
            default: return (v == 10'h3FF) ? 10'h3FF : v + 10'h001;
        endcase
    endfunction

    // bounded wait until the block leaves its busy states
    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge clk_in);
            #1 n++;
        end while (busy !== 1'b0 && n < 5000);
        `CHK("idle", 1'b0, busy)
    endtask

    // one whole frame, then settle before the next command
    task automatic send(logic [3:0] cmd, logic [3:0] addr, logic [15:0] data);
        host_u.xfer({cmd, addr, data}, 24, rx);
        repeat (8) @(posedge clk_in);
        wait_idle();
    endtask

    task automatic final_report();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // the tests need about 45k clocks, so 90k can only mean a hang
    initial begin
        repeat (90000) @(posedge clk_in);
        error_cnt++;
        final_report();
    end

    initial begin
        reset_in = 1'b1;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        wait_idle();
        `CHK("factory", `DPNV_WIPER_MID, wiper)
        `CHK("boot_pulse", 1, host_u.rdy_cnt)
        // load, step, read back: end stops first, then random positions
        for (i = 0; i < 16; i++) begin
            w = (i < 4) ? {10{i[0]}} : 10'(rnd());
            send(4'hB, 4'h0, {6'h00, w});
            `CHK("load", w, wiper)
            send(4'(5 + i % 4), 4'h0, 16'h0000);
            w = step_exp(w, 4'(5 + i % 4));
            `CHK("step", w, wiper)
            send(4'h9, 4'h0, 16'h0000);
            send(4'h0, 4'h0, 16'h0000);
            `CHK("wiper_rd", {4'h9, 4'h0, 6'h00, w}, rx)
        end
        // a frame one bit short is dropped
        send(4'hB, 4'h0, 16'h0155);
        host_u.xfer({4'hB, 4'h0, 16'h02AA}, 23, rx);
        repeat (8) @(posedge clk_in);
        #1;
        `CHK("short", 10'h155, wiper)
        // store; a frame sent while the store runs must be ignored
        w = 10'(rnd());
        send(4'hB, 4'h0, {6'h00, w});
        c = host_u.rdy_cnt;
        host_u.xfer({4'h2, 4'h0, 16'h0000}, 24, rx);
        t0 = $time;
        repeat (8) @(posedge clk_in);
        #1;
        `CHK("busy", 1'b1, busy)
        host_u.xfer({4'hB, 4'h0, {6'h00, ~w}}, 24, rx);
        wait_idle();
        `CHK("ignored", w, wiper)
        `CHK("wr_time", 1'b1, ($time - t0) >= WR_CYC * 10)
        `CHK("store_pulse", c + 1, host_u.rdy_cnt)
        send(4'hB, 4'h0, {6'h00, ~w});
        send(4'h1, 4'h0, 16'h0000);
        `CHK("recall", w, wiper)
        `CHK("recall_pulse", c + 2, host_u.rdy_cnt)
        // reset in mid-run brings back the saved setting
        send(4'hB, 4'h0, {6'h00, ~w});
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        wait_idle();
        `CHK("power_up", w, wiper)
        // user words, with one address past the end
        for (i = 0; i < 15; i++) begin
            ud[i] = 16'(rnd());
            send(4'h3, 4'(i), ud[i]);
        end
        for (i = 0; i < 15; i++) begin
            send(4'h4, 4'(i), 16'h0000);
            send(4'h0, 4'h0, 16'h0000);
            `CHK("user_rd", {4'h4, 4'(i), ((i < 14) ? ud[i] : 16'h0000)}, rx)
        end
        final_report();
    end
endmodule
